// ### dv/tac_fan_model.sv
/*
 * Fan tachometer model: a square wave of fixed period while running.
 * Assumes an open-collector tach with pull-up, so the pin idles high.
 */
`timescale 1ns/1ps
module tac_fan_model #(
   parameter int HALF_CYC = 8880
) (
   input  wire logic i_run,
   output logic      o_tach
);
   // Two tach periods per turn; only the pin period matters here
   initial begin
      o_tach = 1'b1;
      #7.3;
      forever begin
         #(HALF_CYC * 25.0);
         o_tach = i_run ? ~o_tach : 1'b1;
      end
   end
endmodule : tac_fan_model

// ### dv/temp_alarm_compare_test.sv
/*
 * Self-checking bench for the temperature alarm compare block.
 * Assumes tac_pkg and tac_fan_model; inputs change at the falling edge.
 */
`timescale 1ns/1ps
module temp_alarm_compare_test;
   localparam int FAN_PER = 17760;
   logic        clk     = 1'b0;
   logic        resetn  = 1'b0;
   logic        conv    = 1'b0;
   logic [11:0] raw     = 12'h000;
   logic        ext     = 1'b0;
   logic [1:0]  mode    = 2'h0;
   logic        res12   = 1'b0;
   logic [7:0]  hi_lim  = 8'h19;
   logic [7:0]  lo_lim  = 8'h00;
   logic [7:0]  cr_lim  = 8'h1E;
   logic [7:0]  rel_lim = 8'h14;
   logic [2:0]  hyst    = 3'h3;
   logic        mask_hi = 1'b0;
   logic        mask_lo = 1'b0;
   logic        rd      = 1'b0;
   logic        xrd     = 1'b0;
   logic        dac_wr  = 1'b0;
   logic [7:0]  dac_in  = 8'h00;
   logic        fan_run = 1'b0;
   logic [1:0]  div1    = 2'h0;
   logic [1:0]  div2    = 2'h1;
   logic        tach1;
   logic        tach2;
   logic [11:0] temp;
   logic        hf;
   logic        lf;
   logic        cf;
   logic        gen_n;
   logic        crit_n;
   logic [7:0]  dac_out;
   logic [7:0]  cnt1;
   logic [7:0]  cnt2;
   int          mismatches   = 0;
   int          total_checks = 0;

   always #12.5 clk = ~clk;

   tac_fan_model #(.HALF_CYC(FAN_PER / 2)) fan_one_i (.i_run(fan_run), .o_tach(tach1));
   tac_fan_model #(.HALF_CYC(FAN_PER / 2)) fan_two_i (.i_run(fan_run), .o_tach(tach2));

   tac_temp_alarm tac_temp_alarm_i (
      .I_SYS_CLK(clk), .I_RESETN(resetn), .I_CONV_DONE(conv), .I_TEMP_RAW(raw),
      .I_EXT_MODE(ext), .I_ALARM_MODE(mode), .I_RES_12(res12), .I_HIGH_LIMIT(hi_lim),
      .I_LOW_LIMIT(lo_lim), .I_CRITICAL_TEMP_LIMIT(cr_lim), .I_UPPER_RELEASE_LIMIT(rel_lim),
      .I_HYSTERESIS_OFFSET(hyst), .I_MASK_HIGH(mask_hi), .I_MASK_LOW(mask_lo),
      .I_STATUS_READ(rd), .I_EXT_STATUS_READ(xrd), .I_DAC_WRITE(dac_wr), .I_DAC_CODE(dac_in),
      .I_TACH_INPUT_ONE(tach1), .I_TACH_INPUT_TWO(tach2), .I_FAN_DIV_ONE(div1),
      .I_FAN_DIV_TWO(div2), .O_TEMP_RESULT(temp), .O_HIGH_FLAG(hf), .O_LOW_FLAG(lf),
      .O_CRIT_FLAG(cf), .O_GEN_ALARM_N(gen_n), .O_CRITICAL_ALARM_LINE_N(crit_n),
      .O_DAC_CODE(dac_out), .O_FAN_COUNT_ONE(cnt1), .O_FAN_COUNT_TWO(cnt2));

   task automatic summarize();
      $display("Checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h at %0t", name, exp, seen, $time);
      end
   endtask : check

   // Flags packed as high, low, critical, general line, critical line
   task automatic alarms(input logic [4:0] exp);
      check("alarm flags", {7'h00, hf, lf, cf, gen_n, crit_n}, {7'h00, exp});
   endtask : alarms

   task automatic stepr(input logic [11:0] r, input logic [4:0] exp);
      @(negedge clk);
      conv = 1'b1;
      raw = r;
      @(negedge clk);
      conv = 1'b0;
      alarms(exp);
   endtask : stepr

   task automatic step(input int d, input logic [4:0] exp);
      stepr(12'(d * 16), exp);
   endtask : step

   task automatic rdc(input logic ext_reg, input logic [4:0] exp);
      @(negedge clk);
      if (ext_reg) xrd = 1'b1;
      else rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      xrd = 1'b0;
      alarms(exp);
   endtask : rdc

   // Fresh reset per scenario, so stale arming never leaks across modes
   task automatic restart(input logic e, input logic [1:0] m);
      @(negedge clk);
      resetn = 1'b0;
      ext = e;
      mode = m;
      repeat (2) @(negedge clk);
      resetn = 1'b1;
   endtask : restart

   task automatic t_reset();
      check("result", temp, 12'h000);
      alarms(5'h03);
      check("dac", {4'h0, dac_out}, 12'h0FF);
      check("fan one", {4'h0, cnt1}, 12'h000);
      check("fan two", {4'h0, cnt2}, 12'h000);
      @(negedge clk);
      dac_wr = 1'b1;
      dac_in = 8'h5A;
      @(negedge clk);
      dac_wr = 1'b0;
      check("dac", {4'h0, dac_out}, 12'h05A);
      restart(1'b0, tac_pkg::MODE_ONCE);
      check("dac", {4'h0, dac_out}, 12'h0FF);
      $display("Test reset and dac finished");
   endtask : t_reset

   task automatic t_format();
      stepr(12'h190, 5'h03);
      check("result", temp, 12'h032);
      stepr(12'hD80, 5'h03);
      check("result", temp, 12'hFB0);
      restart(1'b1, tac_pkg::MODE_COMP);
      res12 = 1'b1;
      stepr(12'h7D0, 5'h14);
      check("result", temp, 12'h7D0);
      stepr(12'h191, 5'h11);
      check("result", temp, 12'h191);
      res12 = 1'b0;
      $display("Test format finished");
   endtask : t_format

   task automatic t_normal();
      restart(1'b0, tac_pkg::MODE_ONCE);
      step(26, 5'h11);
      rdc(1'b0, 5'h03);
      step(31, 5'h03);
      step(20, 5'h03);
      step(26, 5'h11);
      mask_hi = 1'b1;
      @(negedge clk);
      alarms(5'h13);
      mask_hi = 1'b0;
      restart(1'b0, tac_pkg::MODE_REP);
      step(26, 5'h11);
      rdc(1'b0, 5'h03);
      step(22, 5'h11);
      rdc(1'b0, 5'h03);
      step(20, 5'h03);
      step(24, 5'h03);
      restart(1'b0, tac_pkg::MODE_COMP);
      step(26, 5'h11);
      rdc(1'b0, 5'h11);
      step(25, 5'h03);
      step(-5, 5'h03);
      stepr(12'h191, 5'h03);
      stepr(12'h198, 5'h11);
      $display("Test normal option finished");
   endtask : t_normal

   task automatic t_ext();
      restart(1'b1, tac_pkg::MODE_REP);
      step(31, 5'h14);
      rdc(1'b0, 5'h06);
      rdc(1'b1, 5'h03);
      step(28, 5'h14);
      rdc(1'b0, 5'h06);
      rdc(1'b1, 5'h03);
      step(27, 5'h11);
      rdc(1'b0, 5'h03);
      step(22, 5'h03);
      step(0, 5'h09);
      rdc(1'b0, 5'h03);
      step(3, 5'h09);
      rdc(1'b0, 5'h03);
      step(4, 5'h03);
      step(0, 5'h09);
      mask_lo = 1'b1;
      @(negedge clk);
      alarms(5'h0B);
      mask_lo = 1'b0;
      restart(1'b1, tac_pkg::MODE_ONCE);
      step(26, 5'h11);
      rdc(1'b0, 5'h03);
      step(26, 5'h03);
      step(22, 5'h03);
      step(26, 5'h11);
      rdc(1'b0, 5'h03);
      step(0, 5'h09);
      rdc(1'b0, 5'h03);
      step(0, 5'h03);
      step(4, 5'h03);
      step(0, 5'h09);
      restart(1'b1, tac_pkg::MODE_COMP);
      hyst = 3'h2;
      step(0, 5'h09);
      rdc(1'b0, 5'h09);
      step(2, 5'h09);
      step(3, 5'h03);
      step(31, 5'h14);
      step(28, 5'h11);
      step(23, 5'h03);
      $display("Test extended option finished");
   endtask : t_ext

   // Pin edges are async to the clock, so one count either way is allowed
   task automatic t_fan();
      int exp1;
      int exp2;
      exp1 = FAN_PER / tac_pkg::FAN_TICK_CYC;
      exp2 = exp1 / 2;
      fan_run = 1'b1;
      repeat (40000) @(negedge clk);
      check("fan one", 12'(int'(cnt1) >= exp1 - 1 && int'(cnt1) <= exp1 + 1), 12'h001);
      check("fan two", 12'(int'(cnt2) >= exp2 - 1 && int'(cnt2) <= exp2 + 1), 12'h001);
      // Divisors 4 and 8; the period in flight at the change is mixed
      div1 = 2'h2;
      div2 = 2'h3;
      exp1 = FAN_PER / (tac_pkg::FAN_TICK_CYC * 4);
      exp2 = FAN_PER / (tac_pkg::FAN_TICK_CYC * 8);
      repeat (36000) @(negedge clk);
      check("fan one div4", 12'(int'(cnt1) >= exp1 - 1 && int'(cnt1) <= exp1 + 1), 12'h001);
      check("fan two div8", 12'(int'(cnt2) >= exp2 - 1 && int'(cnt2) <= exp2 + 1), 12'h001);
      fan_run = 1'b0;
      $display("Test fan count finished");
   endtask : t_fan

   initial begin
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      t_reset();
      t_format();
      t_normal();
      t_ext();
      t_fan();
      summarize();
   end

   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      $display("Watchdog expired");
      summarize();
   end
endmodule : temp_alarm_compare_test

// ### rtl/tac_pkg.sv
/*
 * Constants and state types for the temperature alarm compare block.
 * Assumes one 40 MHz system clock and an active-low asynchronous reset.
 */
// Notes on behaviour
// - Fan count assumes two tach pulses per turn
// - Fan DAC takes an 8-bit code
// - DAC code is full scale after reset
// - Temperature 9 or 12 bit, compared to limits
// - Limits are 8-bit two's complement, 1 degree
// - Default result is 9-bit, half degree
// - Extended mode may give 12-bit sixteenth degree
// - Hysteresis offset is 3-bit unsigned degrees
// - Critical line stays off in normal modes
// - Normal and extended, each three alarm modes
// - Normal repetitive retriggers above release limit
// - Normal one-time rearms at release limit
// - Zeroed controls select normal one-time mode
// - Normal comparator follows upper limit, ignores lower
// - Status read clears general, mode read critical
// - Extended repetitive low alarm with hysteresis release
// - Extended repetitive high alarm with hysteresis release
// - Extended repetitive critical alarm with hysteresis
// - Extended one-time fires once, rearms past hysteresis
// - Extended comparator low releases above low plus hysteresis
// - Extended comparator high and critical release below
// - Status read clears high and low flags and general line, except in comparator mode
// - Flag drives general line only when unmasked
package tac_pkg;

   localparam int          CLK_HZ        = 40_000_000;
   // Count rate at divisor 1: 22.5 kHz doubled for two pulses per turn
   localparam int          FAN_TICK_HZ   = 45_000;
   localparam int          FAN_TICK_CYC  = CLK_HZ / FAN_TICK_HZ;
   localparam logic [9:0]  FAN_TICK_LAST = 10'(FAN_TICK_CYC - 1);
   localparam logic [7:0]  FAN_COUNT_MAX = 8'hFF;
   localparam logic [7:0]  DAC_RESET     = 8'hFF;

   // Alarm mode codes; all-zero is one-time
   localparam logic [1:0]  MODE_ONCE     = 2'h0;
   localparam logic [1:0]  MODE_REP      = 2'h1;
   localparam logic [1:0]  MODE_COMP     = 2'h2;

   localparam int          TEMP_W        = 12;
   localparam int          CMP_W         = 13;
   localparam int          RES9_DROP     = 3;

   typedef struct packed {
      logic [TEMP_W-1:0] result;
      logic              hi_trip;
      logic              lo_trip;
      logic              cr_trip;
      logic              hi_armed;
      logic              lo_armed;
      logic              cr_armed;
      logic              hi_flag;
      logic              lo_flag;
      logic              cr_flag;
      logic              gen_alarm_n;
      logic              crit_alarm_n;
      logic [7:0]        dac;
      logic [9:0]        tick_cnt;
      logic              fan_tick;
   } tac_state_s;

   typedef struct packed {
      logic       sync1;
      logic       sync2;
      logic       prev;
      logic [2:0] pre;
      logic [7:0] acc;
      logic [7:0] count;
   } tac_tach_s;

endpackage : tac_pkg

// ### rtl/tac_tach_count.sv
/*
 * Fan tachometer period counter: counts scaled base ticks over one
 * tach period, saturating at full scale.
 * Assumes a one-cycle base tick pulse on the same clock; the tach pin is
 * asynchronous and is synchronised here.
 */
`timescale 1ns/1ps
module tac_tach_count (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_tick,
   input  wire logic [1:0] i_div,
   input  wire logic       i_tach,
   output logic [7:0]      o_count
);

   tac_pkg::tac_tach_s st;
   tac_pkg::tac_tach_s next_st;
   logic [3:0]         pre_lim;
   logic               edge_seen;

   // Divisor code 0..3 selects 1, 2, 4 or 8
   assign pre_lim   = (4'h1 << i_div) - 4'h1;
   assign edge_seen = st.sync2 & ~st.prev;

   always_comb begin
      next_st       = st;
      next_st.sync1 = i_tach;
      next_st.sync2 = st.sync1;
      next_st.prev  = st.sync2;
      if (edge_seen) begin
         // One full period between rising edges gives the count
         next_st.count = st.acc;
         next_st.acc   = 8'h00;
         next_st.pre   = 3'h0;
      end else if (i_tick) begin
         if (st.pre == pre_lim[2:0]) begin
            next_st.pre = 3'h0;
            if (st.acc != tac_pkg::FAN_COUNT_MAX) begin
               next_st.acc = st.acc + 8'h01;
            end
         end else begin
            next_st.pre = st.pre + 3'h1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         // Pin idles high; a zero here would fake an edge after reset
         st       <= '0;
         st.sync1 <= 1'b1;
         st.sync2 <= 1'b1;
         st.prev  <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign o_count = st.count;

   a_tach_count_hold : assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !edge_seen |=> $stable(o_count))
      else $error("Fan count changed without a tach edge");

   c_tach_saturate : cover property (@(posedge i_clk) disable iff (!i_rst_n)
      edge_seen && st.acc == tac_pkg::FAN_COUNT_MAX);

endmodule : tac_tach_count

// ### rtl/tac_temp_alarm.sv
/*
 * Temperature result formatting, limit compare and alarm lines, fan DAC
 * code holding and two fan tach counters.
 * Assumes the conversion strobe, raw result, limits, mode and read strobes
 * come from logic on the same clock; tach inputs are pins.
 */
`timescale 1ns/1ps
module tac_temp_alarm (
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_RESETN,
   input  wire logic        I_CONV_DONE,
   input  wire logic [11:0] I_TEMP_RAW,
   input  wire logic        I_EXT_MODE,
   input  wire logic [1:0]  I_ALARM_MODE,
   input  wire logic        I_RES_12,
   input  wire logic [7:0]  I_HIGH_LIMIT,
   input  wire logic [7:0]  I_LOW_LIMIT,
   input  wire logic [7:0]  I_CRITICAL_TEMP_LIMIT,
   input  wire logic [7:0]  I_UPPER_RELEASE_LIMIT,
   input  wire logic [2:0]  I_HYSTERESIS_OFFSET,
   input  wire logic        I_MASK_HIGH,
   input  wire logic        I_MASK_LOW,
   input  wire logic        I_STATUS_READ,
   input  wire logic        I_EXT_STATUS_READ,
   input  wire logic        I_DAC_WRITE,
   input  wire logic [7:0]  I_DAC_CODE,
   input  wire logic        I_TACH_INPUT_ONE,
   input  wire logic        I_TACH_INPUT_TWO,
   input  wire logic [1:0]  I_FAN_DIV_ONE,
   input  wire logic [1:0]  I_FAN_DIV_TWO,
   output logic [11:0]      O_TEMP_RESULT,
   output logic             O_HIGH_FLAG,
   output logic             O_LOW_FLAG,
   output logic             O_CRIT_FLAG,
   output logic             O_GEN_ALARM_N,
   output logic             O_CRITICAL_ALARM_LINE_N,
   output logic [7:0]       O_DAC_CODE,
   output logic [7:0]       O_FAN_COUNT_ONE,
   output logic [7:0]       O_FAN_COUNT_TWO
);

   tac_pkg::tac_state_s st;
   tac_pkg::tac_state_s next_st;

   logic                 res12;
   logic                 comp;
   logic signed [12:0]   t_cmp;
   logic signed [12:0]   hi_lim;
   logic signed [12:0]   lo_lim;
   logic signed [12:0]   cr_lim;
   logic signed [12:0]   rel_lim;
   logic signed [12:0]   hy;
   logic signed [12:0]   hi_rel_lim;
   logic                 hi_set;
   logic                 hi_rel;
   logic                 lo_set;
   logic                 lo_rel;
   logic                 cr_set;
   logic                 cr_rel;
   logic [2:0]           hi_step;
   logic [2:0]           lo_step;
   logic [2:0]           cr_step;

   // Limits in whole degrees, moved to sixteenth-degree units
   function automatic logic signed [12:0] tac_align(input logic [7:0] lim);
      tac_align = {lim[7], lim, 4'h0};
   endfunction : tac_align

   // Returns {trip, armed, fire} for one limit after a conversion
   function automatic logic [2:0] tac_step(input logic       set,
                                           input logic       rel,
                                           input logic       trip,
                                           input logic       armed,
                                           input logic [1:0] mode);
      logic t;
      logic a;
      logic f;
      t = set ? 1'b1 : (rel ? 1'b0 : trip);
      a = rel ? 1'b1 : armed;
      if (mode == tac_pkg::MODE_ONCE) begin
         f = set & armed;
         if (f) begin
            a = 1'b0;
         end
      end else begin
         f = t;
      end
      tac_step = {t, a, f};
   endfunction : tac_step

   assign res12 = I_EXT_MODE & I_RES_12;
   assign comp  = (I_ALARM_MODE == tac_pkg::MODE_COMP);

   // A 9-bit result compares with its dropped bits as zero
   assign t_cmp = res12 ? {I_TEMP_RAW[11], I_TEMP_RAW}
                        : {I_TEMP_RAW[11], I_TEMP_RAW[11:3], 3'h0};
   assign hi_lim  = tac_align(I_HIGH_LIMIT);
   assign lo_lim  = tac_align(I_LOW_LIMIT);
   assign cr_lim  = tac_align(I_CRITICAL_TEMP_LIMIT);
   assign rel_lim = tac_align(I_UPPER_RELEASE_LIMIT);
   assign hy      = {6'h00, I_HYSTERESIS_OFFSET, 4'h0};

   // Normal comparator releases at the upper limit itself
   assign hi_rel_lim = I_EXT_MODE ? (hi_lim - hy)
                                  : (comp ? hi_lim : rel_lim);
   assign hi_set = t_cmp > hi_lim;
   assign hi_rel = t_cmp <= hi_rel_lim;
   assign lo_set = I_EXT_MODE & (t_cmp <= lo_lim);
   assign lo_rel = t_cmp > (lo_lim + hy);
   assign cr_set = I_EXT_MODE & (t_cmp > cr_lim);
   // Critical release taken as critical limit minus hysteresis
   assign cr_rel = t_cmp <= (cr_lim - hy);

   assign hi_step = tac_step(hi_set, hi_rel, st.hi_trip, st.hi_armed, I_ALARM_MODE);
   assign lo_step = tac_step(lo_set, lo_rel, st.lo_trip, st.lo_armed, I_ALARM_MODE);
   assign cr_step = tac_step(cr_set, cr_rel, st.cr_trip, st.cr_armed, I_ALARM_MODE);

   always_comb begin
      next_st          = st;
      next_st.fan_tick = 1'b0;
      if (st.tick_cnt == tac_pkg::FAN_TICK_LAST) begin
         next_st.tick_cnt = 10'h000;
         next_st.fan_tick = 1'b1;
      end else begin
         next_st.tick_cnt = st.tick_cnt + 10'h001;
      end

      if (I_DAC_WRITE) begin
         next_st.dac = I_DAC_CODE;
      end

      // Clears first so a conversion in the same cycle wins
      if (I_STATUS_READ && !comp) begin
         next_st.hi_flag = 1'b0;
         next_st.lo_flag = 1'b0;
      end
      if (I_EXT_STATUS_READ && !comp) begin
         next_st.cr_flag = 1'b0;
      end

      if (I_CONV_DONE) begin
         next_st.result = res12 ? I_TEMP_RAW
                                : {{3{I_TEMP_RAW[11]}}, I_TEMP_RAW[11:3]};
         {next_st.hi_trip, next_st.hi_armed} = hi_step[2:1];
         {next_st.lo_trip, next_st.lo_armed} = lo_step[2:1];
         {next_st.cr_trip, next_st.cr_armed} = cr_step[2:1];
         if (comp) begin
            next_st.hi_flag = hi_step[2];
            next_st.lo_flag = lo_step[2];
            next_st.cr_flag = cr_step[2];
         end else begin
            next_st.hi_flag = next_st.hi_flag | hi_step[0];
            next_st.lo_flag = next_st.lo_flag | lo_step[0];
            next_st.cr_flag = next_st.cr_flag | cr_step[0];
         end
      end

      // Normal option has no lower or critical alarm at all
      if (!I_EXT_MODE) begin
         next_st.lo_trip  = 1'b0;
         next_st.lo_flag  = 1'b0;
         next_st.lo_armed = 1'b1;
         next_st.cr_trip  = 1'b0;
         next_st.cr_flag  = 1'b0;
         next_st.cr_armed = 1'b1;
      end

      next_st.gen_alarm_n  = ~((next_st.hi_flag & ~I_MASK_HIGH)
                              | (next_st.lo_flag & ~I_MASK_LOW));
      next_st.crit_alarm_n = ~next_st.cr_flag;
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         st              <= '0;
         st.hi_armed     <= 1'b1;
         st.lo_armed     <= 1'b1;
         st.cr_armed     <= 1'b1;
         st.gen_alarm_n  <= 1'b1;
         st.crit_alarm_n <= 1'b1;
         st.dac          <= tac_pkg::DAC_RESET;
      end else begin
         st <= next_st;
      end
   end

   tac_tach_count u_tach_one (
      .i_clk   (I_SYS_CLK),
      .i_rst_n (I_RESETN),
      .i_tick  (st.fan_tick),
      .i_div   (I_FAN_DIV_ONE),
      .i_tach  (I_TACH_INPUT_ONE),
      .o_count (O_FAN_COUNT_ONE)
   );

   tac_tach_count u_tach_two (
      .i_clk   (I_SYS_CLK),
      .i_rst_n (I_RESETN),
      .i_tick  (st.fan_tick),
      .i_div   (I_FAN_DIV_TWO),
      .i_tach  (I_TACH_INPUT_TWO),
      .o_count (O_FAN_COUNT_TWO)
   );

   assign O_TEMP_RESULT           = st.result;
   assign O_HIGH_FLAG             = st.hi_flag;
   assign O_LOW_FLAG              = st.lo_flag;
   assign O_CRIT_FLAG             = st.cr_flag;
   assign O_GEN_ALARM_N           = st.gen_alarm_n;
   assign O_CRITICAL_ALARM_LINE_N = st.crit_alarm_n;
   assign O_DAC_CODE              = st.dac;

   // Zeroed mode code and option select normal one-time
   logic mode_default;
   assign mode_default = (I_ALARM_MODE == tac_pkg::MODE_ONCE) & ~I_EXT_MODE;

   default clocking cb @(posedge I_SYS_CLK);
   endclocking
   default disable iff (!I_RESETN);

   a_dac_write_code : assert property (
      I_DAC_WRITE |=> O_DAC_CODE == $past(I_DAC_CODE))
      else $error("DAC code not taken on write");

   a_dac_hold_full : assert property (
      !I_DAC_WRITE |=> $stable(O_DAC_CODE))
      else $error("DAC code moved without a write");

   a_crit_off_normal : assert property (
      !I_EXT_MODE |=> O_CRITICAL_ALARM_LINE_N && !O_LOW_FLAG)
      else $error("Critical or low alarm active in normal option");

   a_result_nine_bit : assert property (
      I_CONV_DONE && !res12 |=> O_TEMP_RESULT == {{3{$past(I_TEMP_RAW[11])}}, $past(I_TEMP_RAW[11:3])})
      else $error("Nine-bit result format wrong");

   a_result_twelve_bit : assert property (
      I_CONV_DONE && res12 |=> O_TEMP_RESULT == $past(I_TEMP_RAW))
      else $error("Twelve-bit result format wrong");

   a_read_clears_flag : assert property (
      I_STATUS_READ && !comp && !I_CONV_DONE |=> !O_HIGH_FLAG && !O_LOW_FLAG)
      else $error("Status read did not clear flags");

   a_mask_gate_line : assert property (
      ##1 (!O_GEN_ALARM_N == ((O_HIGH_FLAG && !$past(I_MASK_HIGH)) || (O_LOW_FLAG && !$past(I_MASK_LOW)))))
      else $error("General line disagrees with flags and masks");

   a_comp_follows_high : assert property (
      I_CONV_DONE && comp && !I_EXT_MODE |=> O_HIGH_FLAG == $past(hi_set))
      else $error("Comparator flag does not follow upper limit");

   a_once_no_refire : assert property (
      I_CONV_DONE && mode_default && !st.hi_armed && !st.hi_flag |=> !O_HIGH_FLAG)
      else $error("One-time alarm fired while disarmed");

   a_rep_retrigger : assert property (
      I_CONV_DONE && !I_EXT_MODE && I_ALARM_MODE == tac_pkg::MODE_REP && st.hi_trip && !hi_rel
      |=> O_HIGH_FLAG)
      else $error("Repetitive alarm did not retrigger");

   a_crit_ext_fire : assert property (
      I_CONV_DONE && I_EXT_MODE && I_ALARM_MODE == tac_pkg::MODE_REP && cr_set |=> !O_CRITICAL_ALARM_LINE_N)
      else $error("Critical alarm missed above critical limit");

   a_result_hold_idle : assert property (
      !I_CONV_DONE |=> $stable(O_TEMP_RESULT))
      else $error("Temperature result moved without a conversion");

   a_rep_high_fire : assert property (
      I_CONV_DONE && I_ALARM_MODE == tac_pkg::MODE_REP && hi_set |=> O_HIGH_FLAG)
      else $error("Repetitive alarm missed above upper limit");

   a_once_high_fire : assert property (
      I_CONV_DONE && I_ALARM_MODE == tac_pkg::MODE_ONCE && hi_set && st.hi_armed |=> O_HIGH_FLAG)
      else $error("Armed one-time alarm did not fire");

   a_flag_latch_hold : assert property (
      O_HIGH_FLAG && !comp && !I_STATUS_READ |=> O_HIGH_FLAG)
      else $error("Latched high flag dropped without a read");

   a_ext_low_fire : assert property (
      I_CONV_DONE && I_EXT_MODE && I_ALARM_MODE != tac_pkg::MODE_ONCE && lo_set |=> O_LOW_FLAG)
      else $error("Low alarm missed at or below lower limit");

   a_ext_low_keep : assert property (
      I_CONV_DONE && I_EXT_MODE && I_ALARM_MODE == tac_pkg::MODE_REP && st.lo_trip && !lo_rel
      |=> O_LOW_FLAG)
      else $error("Repetitive low alarm did not retrigger");

   a_ext_crit_keep : assert property (
      I_CONV_DONE && I_EXT_MODE && I_ALARM_MODE == tac_pkg::MODE_REP && st.cr_trip && !cr_rel
      |=> !O_CRITICAL_ALARM_LINE_N)
      else $error("Repetitive critical alarm did not retrigger");

   a_comp_high_release : assert property (
      I_CONV_DONE && I_EXT_MODE && comp && t_cmp <= hi_lim - hy |=> !O_HIGH_FLAG)
      else $error("Comparator high alarm held below release point");

   a_comp_low_release : assert property (
      I_CONV_DONE && I_EXT_MODE && comp && t_cmp > lo_lim + hy |=> !O_LOW_FLAG)
      else $error("Comparator low alarm held above release point");

   a_comp_crit_release : assert property (
      I_CONV_DONE && I_EXT_MODE && comp && t_cmp <= cr_lim - hy |=> O_CRITICAL_ALARM_LINE_N)
      else $error("Comparator critical alarm held below release point");

   a_ext_read_clear : assert property (
      I_EXT_STATUS_READ && !comp && !I_CONV_DONE |=> !O_CRIT_FLAG && O_CRITICAL_ALARM_LINE_N)
      else $error("Extended status read did not clear critical alarm");

   a_fan_tick_pulse : assert property (
      st.fan_tick |=> !st.fan_tick)
      else $error("Fan base tick longer than one cycle");

   c_high_alarm   : cover property (I_CONV_DONE && hi_set ##1 !O_GEN_ALARM_N);
   c_crit_alarm   : cover property (I_EXT_MODE && I_CONV_DONE ##1 !O_CRITICAL_ALARM_LINE_N);
   c_low_ext_comp : cover property (I_EXT_MODE && comp && I_CONV_DONE && lo_set);
   c_read_clear   : cover property (O_HIGH_FLAG && I_STATUS_READ ##1 O_GEN_ALARM_N);

endmodule : tac_temp_alarm
